// ### core/rqsb_regs.vh
// Purpose: Shared constants for the request sideband start-field decoder.
// Assumes: Included by bare name from the sideband decoder's design file only.
// Notes:   Byte offsets are APB byte addresses, one 32-bit word each.
`ifndef RQSB_REGS_VH
`define RQSB_REGS_VH

// Bus, stream and packet counter widths.
`define RQSB_ADDR_W     8
`define RQSB_DATA_W     32
`define RQSB_SB_W       26
`define RQSB_CNT_W      16

// Sideband word field positions.
`define RQSB_LEAD_LSB   0
`define RQSB_FINAL_LSB  8
`define RQSB_OFS_LSB    16
`define RQSB_SOP_LSB    20
`define RQSB_PTRA_LSB   22
`define RQSB_PTRB_LSB   24

// Start-of-packet field codes with straddling on.
`define RQSB_SOP_NONE   2'h0
`define RQSB_SOP_ONE    2'h1
`define RQSB_SOP_RSVD   2'h2
`define RQSB_SOP_TWO    2'h3

// Start lane pointer codes.
`define RQSB_PTR_LANE0  2'h0
`define RQSB_PTR_LANE32 2'h2

// Register byte offsets.
`define RQSB_CTRL_OFS   8'h00
`define RQSB_STAT_OFS   8'h04
`define RQSB_SLOTA_OFS  8'h08
`define RQSB_SLOTB_OFS  8'h0C
`define RQSB_COUNT_OFS  8'h10

// Control register bits and reset value.
`define RQSB_CTRL_STRADDLE 0
`define RQSB_CTRL_ACCEPT   1
`define RQSB_CTRL_RST      2'h2

// Status register bits.
`define RQSB_STAT_INPKT    0
`define RQSB_STAT_RSVD     1

// Slot register field positions.
`define RQSB_SLOT_FINAL    4
`define RQSB_SLOT_OFS      8
`define RQSB_SLOT_LANE     10

`endif

// ### core/rqsb_slot_capture.v
// Purpose: Holds the byte masks, offset and lane of one starting packet.
// Assumes: Load is a single-cycle strobe on an accepted first beat.
// Notes:   Instantiated once per packet slot of a beat.
`timescale 1ns/1ns
`default_nettype none
module rqsb_slot_capture (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       load,
	input  wire [3:0] lead_in,
	input  wire [3:0] final_in,
	input  wire [1:0] ofs_in,
	input  wire       lane32_in,
	output reg  [3:0] lead_ff,
	output reg  [3:0] final_ff,
	output reg  [1:0] ofs_ff,
	output reg        lane32_ff
);

	// Fields are taken only on the load strobe and held until the next.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lead_ff   <= 4'h0;
			final_ff  <= 4'h0;
			ofs_ff    <= 2'h0;
			lane32_ff <= 1'b0;
		end else if (load) begin
			lead_ff   <= lead_in;
			final_ff  <= final_in;
			ofs_ff    <= ofs_in;
			lane32_ff <= lane32_in;
		end
	end

endmodule
`default_nettype wire

// ### core/rqsb_sideband.v
// Purpose: Decodes the low sideband fields of the request stream.
// Assumes: Stream and APB share pclk; the client is on the same clock.
// Notes:   Up to two packets are captured per beat with straddling on.
//
// Operation
// - Both masks are captured only on a first beat with valid and ready.
// - Offset bits 1:0 serve the first packet; bits 3:2 mean nothing.
// - With straddling, 00 none, 01 one, 11 two, 10 reserved.
// - Without straddling the start field is ignored entirely.
// - With straddling, the first start pointer 00 is lane 0, 10 is lane 32.
`timescale 1ns/1ns
`default_nettype none
`include "rqsb_regs.vh"
module rqsb_sideband (
	input  wire                    pclk,
	input  wire                    presetn,
	input  wire                    psel,
	input  wire                    penable,
	input  wire                    pwrite,
	input  wire [`RQSB_ADDR_W-1:0] paddr,
	input  wire [`RQSB_DATA_W-1:0] pwdata,
	output reg                     pready,
	output reg  [`RQSB_DATA_W-1:0] prdata,
	output reg                     pslverr,
	input  wire                    request_beat_valid,
	input  wire                    request_beat_last,
	input  wire [`RQSB_SB_W-1:0]   request_sideband_word,
	output reg                     request_beat_ready,
	output reg                     slot_a_strobe,
	output reg                     slot_b_strobe,
	output wire [3:0]              slot_a_lead_mask,
	output wire [3:0]              slot_a_final_mask,
	output wire [1:0]              slot_a_offset,
	output wire                    slot_a_lane32,
	output wire [3:0]              slot_b_lead_mask,
	output wire [3:0]              slot_b_final_mask,
	output wire                    slot_b_lane32
);

	// Control and status state.
	reg  [1:0]              ctrl_ff;
	reg                     in_pkt_ff;
	reg                     nxt_in_pkt;
	reg                     rsvd_ff;
	reg                     nxt_rsvd;
	reg  [`RQSB_CNT_W-1:0]  count_ff;
	reg  [`RQSB_CNT_W-1:0]  nxt_count;

	// Beat decode results.
	reg                     start_a;
	reg                     start_b;
	reg                     lane32_a;
	reg                     rsvd_hit;

	// Bus decode helpers.
	reg                     nxt_pready;
	reg  [`RQSB_DATA_W-1:0] nxt_prdata;
	reg                     nxt_pslverr;
	wire                    wr_commit;
	wire                    stat_clear;

	// Sideband field slices.
	wire                    take;
	wire                    straddle;
	wire [1:0]              sop;
	wire [1:0]              ptr_a;
	wire [1:0]              ptr_b;
	wire [1:0]              ofs_a;
	wire [1:0]              sb_slot_b_ofs;

	// Field slices of the beat; the client holds them while ready is low.
	// A stalled beat is therefore captured once, with the values that
	// stand at the edge where valid and ready are both high.
	assign take     = request_beat_valid & request_beat_ready;
	assign straddle = ctrl_ff[`RQSB_CTRL_STRADDLE];
	assign sop      = request_sideband_word[`RQSB_SOP_LSB +: 2];
	assign ptr_a    = request_sideband_word[`RQSB_PTRA_LSB +: 2];
	assign ptr_b    = request_sideband_word[`RQSB_PTRB_LSB +: 2];
	// Only the two low offset bits carry meaning; the high pair is dropped.
	assign ofs_a    = request_sideband_word[`RQSB_OFS_LSB +: 2];
	// The second packet carries no offset of its own, so its slot is fed
	// zero and the slot's offset output is left open.
	assign sb_slot_b_ofs = 2'h0;

	// Work out which packets start in this beat.
	always @* begin
		start_a  = 1'b0;
		start_b  = 1'b0;
		lane32_a = 1'b0;
		rsvd_hit = 1'b0;
		if (straddle) begin
			// Start field decode with straddling on.
			case (sop)
				`RQSB_SOP_ONE: begin
					start_a = take;
				end
				`RQSB_SOP_TWO: begin
					start_a = take;
					start_b = take;
				end
				`RQSB_SOP_RSVD: begin
					rsvd_hit = take;
				end
				default: begin
					// Code 00: nothing starts, the beat continues a packet.
					start_a = 1'b0;
				end
			endcase
			// Lane of the first packet; reserved codes are flagged.
			if (start_a) begin
				lane32_a = (ptr_a == `RQSB_PTR_LANE32);
				if (ptr_a != `RQSB_PTR_LANE0 &&
				    ptr_a != `RQSB_PTR_LANE32) begin
					rsvd_hit = 1'b1;
				end
			end
			// The second packet can only begin at lane 32.
			// A wrong pointer is flagged, but the capture still goes ahead.
			if (start_b && ptr_b != `RQSB_PTR_LANE32) begin
				rsvd_hit = 1'b1;
			end
		end else begin
			// The start field is optional here, so beats are counted
			// from the last flag instead of trusting the client's bits.
			start_a = take & ~in_pkt_ff;
		end
	end

	// Packet tracking follows the last flag in every mode.
	// It feeds the status word and stands in for the unused start field.
	always @* begin
		nxt_in_pkt = in_pkt_ff;
		if (take) begin
			nxt_in_pkt = ~request_beat_last;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_pkt_ff <= 1'b0;
		end else begin
			in_pkt_ff <= nxt_in_pkt;
		end
	end

	// Count of packets started, wrapping silently at the top.
	// Software that wants a total must read it before sixteen bits wrap;
	// a wider count was not worth the extra flops for a debug aid.
	always @* begin
		nxt_count = count_ff +
		            {{(`RQSB_CNT_W-1){1'b0}}, start_a} +
		            {{(`RQSB_CNT_W-1){1'b0}}, start_b};
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= {`RQSB_CNT_W{1'b0}};
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Slot for the first packet of a beat: low nibbles of both masks.
	rqsb_slot_capture u_slot_a (
		.pclk      (pclk),
		.presetn   (presetn),
		.load      (start_a),
		.lead_in   (request_sideband_word[`RQSB_LEAD_LSB +: 4]),
		.final_in  (request_sideband_word[`RQSB_FINAL_LSB +: 4]),
		.ofs_in    (ofs_a),
		.lane32_in (lane32_a),
		.lead_ff   (slot_a_lead_mask),
		.final_ff  (slot_a_final_mask),
		.ofs_ff    (slot_a_offset),
		.lane32_ff (slot_a_lane32)
	);

	// Slot for the second packet: high nibbles, always lane 32.
	rqsb_slot_capture u_slot_b (
		.pclk      (pclk),
		.presetn   (presetn),
		.load      (start_b),
		.lead_in   (request_sideband_word[`RQSB_LEAD_LSB+4 +: 4]),
		.final_in  (request_sideband_word[`RQSB_FINAL_LSB+4 +: 4]),
		.ofs_in    (sb_slot_b_ofs),
		.lane32_in (1'b1),
		.lead_ff   (slot_b_lead_mask),
		.final_ff  (slot_b_final_mask),
		.ofs_ff    (),
		.lane32_ff (slot_b_lane32)
	);

	// Strobes mark the cycle in which the slot outputs are fresh.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_a_strobe <= 1'b0;
			slot_b_strobe <= 1'b0;
		end else begin
			slot_a_strobe <= start_a;
			slot_b_strobe <= start_b;
		end
	end

	// Ready follows the accept bit one cycle late, from a flop.
	// The extra cycle keeps bus decode out of the stream's ready path; a
	// beat offered in that cycle is still taken under the old setting.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			request_beat_ready <= 1'b0;
		end else begin
			request_beat_ready <= ctrl_ff[`RQSB_CTRL_ACCEPT];
		end
	end

	// A write commits at the edge where the master sees pready high.
	// Refused writes to unmapped words leave every register untouched.
	assign wr_commit  = psel & penable & pready & pwrite & ~pslverr;
	assign stat_clear = wr_commit && paddr == `RQSB_STAT_OFS &&
	                    pwdata[`RQSB_STAT_RSVD];

	// Control register write.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `RQSB_CTRL_RST;
		end else if (wr_commit && paddr == `RQSB_CTRL_OFS) begin
			ctrl_ff <= pwdata[1:0];
		end
	end

	// Sticky reserved-code flag; a new hit beats a same-cycle clear.
	// Letting the hit win means no reserved code is ever lost to a clear.
	always @* begin
		nxt_rsvd = rsvd_ff;
		if (stat_clear) begin
			nxt_rsvd = 1'b0;
		end
		if (rsvd_hit) begin
			nxt_rsvd = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsvd_ff <= 1'b0;
		end else begin
			rsvd_ff <= nxt_rsvd;
		end
	end

	// One wait state: pready rises in the first access cycle's edge.
	// Read data and error are forced to zero outside the answer cycle, so
	// the bus never shows a stale word between transfers.
	always @* begin
		nxt_pready  = psel & penable & ~pready;
		nxt_prdata  = {`RQSB_DATA_W{1'b0}};
		nxt_pslverr = 1'b0;
		if (paddr == `RQSB_CTRL_OFS) begin
			nxt_prdata[1:0] = ctrl_ff;
		end else if (paddr == `RQSB_STAT_OFS) begin
			nxt_prdata[`RQSB_STAT_INPKT] = in_pkt_ff;
			nxt_prdata[`RQSB_STAT_RSVD]  = rsvd_ff;
		end else if (paddr == `RQSB_SLOTA_OFS) begin
			nxt_prdata[3:0]  = slot_a_lead_mask;
			nxt_prdata[7:4]  = slot_a_final_mask;
			nxt_prdata[9:8]  = slot_a_offset;
			nxt_prdata[10]   = slot_a_lane32;
		end else if (paddr == `RQSB_SLOTB_OFS) begin
			nxt_prdata[3:0]  = slot_b_lead_mask;
			nxt_prdata[7:4]  = slot_b_final_mask;
			nxt_prdata[10]   = slot_b_lane32;
		end else if (paddr == `RQSB_COUNT_OFS) begin
			nxt_prdata[`RQSB_CNT_W-1:0] = count_ff;
		end else begin
			// Unmapped words read zero and flag an error.
			nxt_pslverr = 1'b1;
		end
		if (!nxt_pready) begin
			nxt_prdata  = {`RQSB_DATA_W{1'b0}};
			nxt_pslverr = 1'b0;
		end
	end

	// Bus answer flops.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= {`RQSB_DATA_W{1'b0}};
			pslverr <= 1'b0;
		end else begin
			pready  <= nxt_pready;
			prdata  <= nxt_prdata;
			pslverr <= nxt_pslverr;
		end
	end

endmodule
`default_nettype wire

// ### tb/rqsb_sideband_checker.sv
// Purpose: Concurrent checks on the sideband decoder's ports.
// Assumes: One clock; reset is asynchronous and active low.
// Notes:   Attached to the design by bind at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module rqsb_sideband_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        request_beat_valid,
	input wire logic        request_beat_ready,
	input wire logic        slot_a_strobe,
	input wire logic        slot_b_strobe,
	input wire logic        slot_a_lane32,
	input wire logic        slot_b_lane32,
	input wire logic [25:0] request_sideband_word,
	input wire logic [3:0]  slot_a_lead_mask,
	input wire logic [3:0]  slot_a_final_mask,
	input wire logic [3:0]  slot_b_lead_mask,
	input wire logic [3:0]  slot_b_final_mask,
	input wire logic [1:0]  slot_a_offset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A taken beat followed by a capture strobe one cycle later.
	sequence took_then_strobe;
		request_beat_valid && request_beat_ready ##1 slot_a_strobe;
	endsequence
	a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready stuck");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	a_strobe_cause: assert property (slot_a_strobe |->
		$past(request_beat_valid && request_beat_ready))
		else $error("capture without handshake");
	a_fields_load: assert property (slot_a_strobe |->
		{slot_a_final_mask, slot_a_lead_mask, slot_a_offset} ==
		$past({request_sideband_word[11:8], request_sideband_word[3:0],
		request_sideband_word[17:16]}))
		else $error("slot a fields wrong");
	// Masks must not move between captures, whatever the stream does.
	a_fields_hold: assert property (!slot_a_strobe && !slot_b_strobe |->
		$stable({slot_a_final_mask, slot_a_lead_mask, slot_b_lead_mask,
		slot_b_final_mask, slot_a_offset}))
		else $error("fields moved");
	a_two_starts: assert property (slot_b_strobe |->
		slot_a_strobe && $past(request_sideband_word[21:20]) == 2'h3)
		else $error("second slot without code 11");
	a_lane_b: assert property (slot_b_strobe |->
		slot_b_lane32 && slot_b_lead_mask == $past(request_sideband_word[7:4]))
		else $error("slot b wrong");
	a_lane_a: assert property (slot_a_strobe && slot_a_lane32 |->
		$past(request_sideband_word[23:22]) == 2'h2)
		else $error("lane 32 without code 10");
	c_capture: cover property (took_then_strobe);
endmodule
bind rqsb_sideband rqsb_sideband_checker rqsb_sideband_checker_i (.pclk,
	.presetn, .psel, .penable, .pready, .pslverr, .request_beat_valid,
	.request_beat_ready, .slot_a_strobe, .slot_b_strobe, .slot_a_lane32,
	.slot_b_lane32, .request_sideband_word, .slot_a_lead_mask,
	.slot_a_final_mask, .slot_b_lead_mask, .slot_b_final_mask, .slot_a_offset);
`default_nettype wire

// ### tb/rqsb_client_model.sv
// Purpose: Client logic that offers one request beat when told to.
// Assumes: The bench pulses go for one cycle with word and last set.
// Notes:   Fields are inverted once taken so stale values never match.
`timescale 1ns/1ns
`default_nettype none
module rqsb_client_model (
	input  wire logic        pclk,
	input  wire logic        go,
	input  wire logic [25:0] word,
	input  wire logic        last,
	input  wire logic        request_beat_ready,
	output var  logic        request_beat_valid = 1'b0,
	output var  logic        request_beat_last = 1'b0,
	output var  logic [25:0] request_sideband_word = 26'h0,
	output var  logic        taken = 1'b0
);
	// Word carries masks, offset, start code and pointers as the bench built.
	always @(posedge pclk) begin
		taken <= 1'b0;
		if (request_beat_valid && request_beat_ready) begin
			request_beat_valid <= 1'b0;
			request_sideband_word <= ~request_sideband_word;
			taken <= 1'b1;
		end else if (go && !request_beat_valid) begin
			request_beat_valid <= 1'b1;
			request_beat_last <= last;
			request_sideband_word <= word;
		end
	end
endmodule
`default_nettype wire

// ### tb/request_sideband_byte_enables_sop_bench.sv
// Purpose: Self-checking bench for the request sideband decoder.
// Assumes: APB answers after one wait; strobes follow a taken beat.
// Notes:   Drivers queue expectations; one monitor compares them.
`timescale 1ns/1ns
`default_nettype none
module request_sideband_byte_enables_sop_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic go = 0, last = 0, strad = 0;
	logic [7:0] paddr = 0, i;
	logic [31:0] pwdata = 0;
	logic [25:0] word = 0, w;
	logic [33:0] e;
	wire logic pready, pslverr, request_beat_valid, request_beat_ready;
	wire logic request_beat_last, slot_a_strobe, slot_b_strobe, taken;
	wire logic slot_a_lane32, slot_b_lane32;
	wire logic [31:0] prdata;
	wire logic [25:0] request_sideband_word;
	wire logic [3:0] slot_a_lead_mask, slot_a_final_mask;
	wire logic [3:0] slot_b_lead_mask, slot_b_final_mask;
	wire logic [1:0] slot_a_offset;
	integer fail_count = 0, checked = 0, seed = 32'hc05f, n, k;
	logic [33:0] qr[$];
	logic [10:0] qa[$], qb[$];
	rqsb_sideband rqsb_sideband_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .request_beat_valid,
		.request_beat_last, .request_sideband_word, .request_beat_ready,
		.slot_a_strobe, .slot_b_strobe, .slot_a_lead_mask, .slot_a_final_mask,
		.slot_a_offset, .slot_a_lane32, .slot_b_lead_mask, .slot_b_final_mask,
		.slot_b_lane32);
	rqsb_client_model rqsb_client_model_i (.pclk, .go, .word, .last,
		.request_beat_ready, .request_beat_valid, .request_beat_last,
		.request_sideband_word, .taken);
	always #50 pclk = ~pclk;
	task results;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Expectation is {read, error, data}; write data are not compared.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] x);
		qr.push_back(x);
		psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk) penable <= 1;
		k = 0;
		do @(posedge pclk); while (!pready && ++k < 20);
		if (k == 20) begin fail_count++; results(); end
		psel <= 0;
		penable <= 0;
		// An idle edge keeps a following setup from reassigning psel now.
		@(posedge pclk);
	endtask
	// Slot a reports lane 32 only with straddling on and pointer code 10.
	task beat(input logic [25:0] x, input logic l, input logic ea, eb);
		if (ea) qa.push_back({x[11:8], x[3:0], x[17:16],
			strad && x[23:22] == 2'h2});
		if (eb) qb.push_back({x[15:12], x[7:4], 3'h1});
		word <= x; last <= l; go <= 1;
		@(posedge pclk) go <= 0;
		n = 0;
		do @(posedge pclk); while (!taken && ++n < 50);
		if (n == 50) begin fail_count++; results(); end
	endtask
	// One monitor pops the oldest note whenever a result appears.
	always @(posedge pclk) begin
		if (slot_a_strobe) chk({slot_a_final_mask, slot_a_lead_mask, slot_a_offset, slot_a_lane32}, qa.pop_front());
		if (slot_b_strobe) chk({slot_b_final_mask, slot_b_lead_mask, 2'h0, slot_b_lane32}, qb.pop_front());
		if (pready) begin
			e = qr.pop_front();
			chk({pslverr, prdata & {32{e[33]}}}, e[32:0]);
		end
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 6; i++) apb(0, i << 2, 0, {1'b1, i == 5, i == 0 ? 32'h0000_0002 : 32'h0000_0000});
		apb(1, 8'h14, 32'hffff_ffff, 34'h1_0000_0000);
		$display("test reset done");
		// Without straddling only first beats after a last count.
		w = 26'($random(seed));
		w[21:20] = 2'h0;
		w[11:8] = 4'h0;
		beat(w, 0, 1, 0);
		w = 26'($random(seed));
		w[21:20] = 2'h3;
		beat(w, 0, 0, 0);
		w = 26'($random(seed));
		beat(w, 1, 0, 0);
		w = 26'($random(seed));
		w[21:20] = 2'h2;
		w[11:8] = 4'h3;
		beat(w, 1, 1, 0);
		$display("test no straddle done");
		apb(1, 8'h00, 32'h0000_0003, 34'h0_0000_0000);
		strad = 1;
		for (i = 0; i < 4; i++) begin
			w = 26'($random(seed));
			w[21:20] = i[1:0];
			w[25:24] = 2'h2;
			w[23:22] = i == 1 ? 2'h0 : 2'h2;
			beat(w, 1, i[0], i == 3);
		end
		apb(0, 8'h04, 0, 34'h2_0000_0002);
		apb(1, 8'h04, 32'h0000_0002, 34'h0_0000_0000);
		apb(0, 8'h04, 0, 34'h2_0000_0000);
		$display("test straddle done");
		// Ready drops while a beat waits; the client must hold it.
		apb(1, 8'h00, 32'h0000_0001, 34'h0_0000_0000);
		w = 26'($random(seed));
		w[21:20] = 2'h1;
		fork
			beat(w, 1, 1, 0);
			begin
				repeat (5) @(posedge pclk);
				chk({request_beat_ready, request_beat_valid}, 2'h1);
				apb(1, 8'h00, 32'h0000_0003, 34'h0_0000_0000);
			end
		join
		apb(0, 8'h10, 0, 34'h2_0000_0006);
		apb(0, 8'h08, 0, {2'b10, 21'h0, w[23:22] == 2'h2, w[17:16], w[11:8], w[3:0]});
		repeat (2) @(posedge pclk);
		chk(qa.size() + qb.size() + qr.size(), 0);
		$display("test stall done");
		results();
	end
endmodule
`default_nettype wire
